// ### asip_assertions.sv
`timescale 1ns/100ps
module asip_assertions (
    input logic clk_sys_i,
    input logic sys_rst_i,
    input logic s_axi_awvalid_i,
    input logic s_axi_awready_o,
    input logic s_axi_wvalid_i,
    input logic s_axi_wready_o,
    input logic s_axi_bvalid_o,
    input logic s_axi_bready_i,
    input logic s_axi_arvalid_i,
    input logic s_axi_arready_o,
    input logic [31:0] s_axi_rdata_o,
    input logic s_axi_rvalid_o,
    input logic s_axi_rready_i,
    input logic tx_irq_o,
    input logic rx_irq_o
);
    // one clock domain
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    property p_wans; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##2 s_axi_bvalid_o; endproperty
    a_wans: assert property (p_wans) else $error("late write answer");
    property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_bref; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
    a_bref: assert property (p_bref) else $error("write taken while answering");
    property p_rans; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
    a_rans: assert property (p_rans) else $error("late read answer");
    property p_rhold; s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");
    property p_rdone; s_axi_rvalid_o && s_axi_rready_i
        |=> !s_axi_rvalid_o ##[1:2] s_axi_arready_o; endproperty
    a_rdone: assert property (p_rdone) else $error("read channel stuck");
    property p_txp; tx_irq_o |=> !tx_irq_o; endproperty
    a_txp: assert property (p_txp) else $error("tx event too long");
    property p_rxp; rx_irq_o |=> !rx_irq_o; endproperty
    a_rxp: assert property (p_rxp) else $error("rx event too long");
endmodule // asip_assertions

// ### asip_defines.vh
`ifndef ASIP_DEFINES_VH
`define ASIP_DEFINES_VH
// Overview of operation
// RULE_01 - infrared features only in 16x mode (fast rate off)
// RULE_02 - pin mode 11, port on: 16x rate clock on request pin
// RULE_03 - infrared enable routes serial pins through encoder and decoder
// RULE_04 - port enable gives pins to the port; clear returns them to latches
// RULE_05 - halt-in-idle stops the port while the system idles
// RULE_06 - request pin simplex when select set, flow control when clear
// RULE_07 - pin usage field picks the serial, clear and request pins
// RULE_08 - wake in sleep: falling edge raises event, next rising edge clears enable
// RULE_09 - echo select loops transmit stream into receiver
// RULE_10 - auto rate measures next 55h character, then clears its enable
// RULE_11 - receive polarity bit: idle low when set, high when clear
// RULE_12 - fast rate select divides by 4, otherwise by 16
// RULE_13 - format field: 9-bit, odd, even or no parity; one or two stops
// RULE_14 - transmit event: per load, load emptying queue, or fully shifted out
// RULE_15 - send break: start, twelve zeros, stop; then hardware clears it
// RULE_16 - transmit enable owns the pin; clearing aborts and empties queue
// RULE_17 - transmit queue full flag is 1 only when no room remains
// RULE_18 - transmitter empty flag is 1 only with shifter and queue empty
// RULE_19 - receive event on 4 held, 3 held, or every character
// RULE_20 - address match in 9-bit mode keeps only ninth-bit-1 characters
// RULE_21 - parity and framing faults show the receive queue head
// RULE_22 - overrun set on overflow; clearing it empties queue and shifter
// RULE_23 - free-running 16-bit rate timer; divider write clears it
// RULE_24 - reading receive data advances queue with its own fault flags
// RULE_25 - infrared encoder sends 3/16-bit pulse per zero; decoder reverses it
`define ASIP_OFF_MODE 5'h00
`define ASIP_OFF_STA 5'h04
`define ASIP_OFF_TXD 5'h08
`define ASIP_OFF_RXD 5'h0c
`define ASIP_OFF_BRG 5'h10
`define ASIP_MODE_WMASK 16'hbbff
`define ASIP_STA_WMASK 16'hece0
`define ASIP_MODE_RST 16'h0000
`define ASIP_STA_RST 16'h0000
`define ASIP_BRG_RST 16'h0000
`define ASIP_M_EN 15
`define ASIP_M_HALT 13
`define ASIP_M_IR 12
`define ASIP_M_RQSX 11
`define ASIP_M_PINS 9:8
`define ASIP_M_WAKE 7
`define ASIP_M_ECHO 6
`define ASIP_M_AUTO 5
`define ASIP_M_RXPOL 4
`define ASIP_M_FAST 3
`define ASIP_M_PD 2:1
`define ASIP_M_STOP2 0
`define ASIP_S_TXIS1 15
`define ASIP_S_TXPOL 14
`define ASIP_S_TXIS0 13
`define ASIP_S_BRK 11
`define ASIP_S_TXON 10
`define ASIP_S_RXIS 7:6
`define ASIP_S_ADDR 5
`define ASIP_S_OVERRUN_FAULT 1
`define ASIP_OVS_STD 4'd15
`define ASIP_OVS_HI 4'd3
`define ASIP_IR_PULSE 4'd3
`define ASIP_IR_HOLD 4'd15
`define ASIP_DEPTH 3'd4
`define ASIP_LEN9 4'd11
`define ASIP_LEN8 4'd10
`define ASIP_BRK_LEN 4'd14
`define ASIP_ABD_FALLS 3'd4
`define ASIP_RESP_OK 2'b00
`define ASIP_RESP_ERR 2'b10
`endif

// ### asip_partner.sv
`timescale 1ns/100ps
module asip_partner #(
    parameter int BIT = 16
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o,
    output logic cts_n_o
);
    logic [7:0] got = 8'h00;
    logic [7:0] sh = 8'h00;
    int i;
    // idle high, always ready
    initial line_o = 1'b1;
    initial cts_n_o = 1'b0;
    // start, n bits lsb first, then a long stop
    task send(input logic [10:0] b, input int n);
        int k;
        @(posedge clk_i);
        line_o <= 1'b0;
        repeat (BIT) @(posedge clk_i);
        for (k = 0; k < n; k++) begin
            line_o <= b[k];
            repeat (BIT) @(posedge clk_i);
        end
        line_o <= 1'b1;
        repeat (2 * BIT) @(posedge clk_i);
    endtask
    // mid-bit sampling of eight data bits only
    always begin
        @(negedge line_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_i);
            sh[i] = line_i;
        end
        got <= sh;
        repeat (BIT) @(posedge clk_i);
    end
endmodule // asip_partner

// ### asip_uart.v
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "asip_defines.vh"
module asip_uart (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire sys_idle_i,
    input wire sys_sleep_i,
    input wire [4:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [4:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire serial_in_pin_i,
    input wire clear_to_send_pin_i,
    output reg serial_out_pin_o,
    output reg serial_out_pin_oe_o,
    output reg request_to_send_pin_o,
    output reg request_to_send_pin_oe_o,
    output reg tx_irq_o,
    output reg rx_irq_o,
    output reg wake_irq_o
);
localparam RX_IDLE = 4'b0001;
localparam RX_START = 4'b0010;
localparam RX_DATA = 4'b0100;
localparam RX_STOP = 4'b1000;

reg [15:0] mode_ff;
reg [15:0] ctl_ff;
reg [15:0] brg_ff;
reg overrun_fault_ff;
reg [4:0] aw_a_ff;
reg aw_have_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
reg w_have_ff;
reg [2:0] rxs_ff;
reg [2:0] ctss_ff;
reg rx_pin_ff;
reg cts_ff;
reg [15:0] bcnt_ff;
reg [8:0] txq [0:3];
reg [2:0] txw_ff;
reg [2:0] txr_ff;
reg [14:0] tx_sh_ff;
reg [3:0] tx_left_ff;
reg [3:0] tx_os_ff;
reg tx_busy_ff;
reg tx_brk_ff;
reg [10:0] rxq [0:3];
reg [2:0] rxw_ff;
reg [2:0] rxr_ff;
reg [3:0] rxst_ff;
reg [3:0] rx_os_ff;
reg [3:0] rx_n_ff;
reg [9:0] rx_sh_ff;
reg rx_prev_ff;
reg [3:0] irh_ff;
reg [23:0] abd_cnt_ff;
reg [2:0] abd_fall_ff;
reg lvl_prev_ff;
reg wk_seen_ff;
reg [15:0] rd_val;

// byte-lane merge of a bus write
function [15:0] mrg;
    input [15:0] old;
    begin
        mrg = {wstrb_ff[1] ? wdata_ff[15:8] : old[15:8],
               wstrb_ff[0] ? wdata_ff[7:0] : old[7:0]};
    end
endfunction

// decoded configuration
wire pin_en = mode_ff[`ASIP_M_EN];
wire run = pin_en & ~(mode_ff[`ASIP_M_HALT] & sys_idle_i); // [RULE_05]
wire fast = mode_ff[`ASIP_M_FAST];
wire ir_on = mode_ff[`ASIP_M_IR] & ~fast; // [RULE_01]
wire [1:0] pins = mode_ff[`ASIP_M_PINS];
wire [1:0] pd = mode_ff[`ASIP_M_PD];
wire nine = (pd == 2'b11);
wire stop2 = mode_ff[`ASIP_M_STOP2];
wire txen = ctl_ff[`ASIP_S_TXON];
wire [3:0] ovs_last = fast ? `ASIP_OVS_HI : `ASIP_OVS_STD; // [RULE_12]

// bus write decode
wire wr_go = aw_have_ff & w_have_ff & ~s_axi_bvalid_o;
wire wr_mode = wr_go & (aw_a_ff == `ASIP_OFF_MODE);
wire wr_sta = wr_go & (aw_a_ff == `ASIP_OFF_STA);
wire wr_txd = wr_go & (aw_a_ff == `ASIP_OFF_TXD);
wire wr_brg = wr_go & (aw_a_ff == `ASIP_OFF_BRG);
wire wr_hit = (aw_a_ff[1:0] == 2'b00) & (aw_a_ff <= `ASIP_OFF_BRG);
wire rd_go = s_axi_arvalid_i & s_axi_arready_o;

// transmit status
wire [2:0] txn = txw_ff - txr_ff;
wire tx_full = (txn == `ASIP_DEPTH); // [RULE_17]
wire tx_empty = ~tx_busy_ff & (txn == 3'd0); // [RULE_18]
wire tx_push = wr_txd & wstrb_ff[0] & ~tx_full;
wire tx_flush = wr_sta & wstrb_ff[1] & txen & ~wdata_ff[`ASIP_S_TXON];
wire cts_ok = (pins != 2'b10) | ~cts_ff; // [RULE_07]
wire tx_load = run & txen & ~tx_busy_ff & (txn != 3'd0) & cts_ok;
wire os_tick = run & (bcnt_ff == brg_ff);
wire tx_bit_end = tx_busy_ff & os_tick & (tx_os_ff == ovs_last);
wire tx_fin = tx_bit_end & (tx_left_ff == 4'd1);
wire brk_done = tx_fin & tx_brk_ff; // [RULE_15]
wire [8:0] txd = txq[txr_ff[1:0]];
wire par_bit = (^txd[7:0]) ^ (pd == 2'b10);
wire tx_line = tx_busy_ff ? tx_sh_ff[0] : 1'b1;
wire ir_pulse = tx_busy_ff & ~tx_sh_ff[0] & (tx_os_ff < `ASIP_IR_PULSE); // [RULE_25]

// receive path
wire rx_lvl = rx_pin_ff ^ mode_ff[`ASIP_M_RXPOL]; // [RULE_11]
wire ir_dec = rx_lvl & (irh_ff == 4'd0); // [RULE_25]
wire rx_bit = mode_ff[`ASIP_M_ECHO] ? tx_line : (ir_on ? ir_dec : rx_lvl); // [RULE_09]
wire rx_samp = os_tick & (rx_os_ff == ovs_last);
wire [3:0] rx_nbits = (pd == 2'b00) ? 4'd8 : 4'd9;
wire [8:0] rx_d = (pd == 2'b00) ? {1'b0, rx_sh_ff[9:2]} :
                  (nine ? rx_sh_ff[9:1] : {1'b0, rx_sh_ff[8:1]});
wire rx_parity_fault = (pd[1] ^ pd[0]) &
               (rx_sh_ff[9] != ((^rx_sh_ff[8:1]) ^ (pd == 2'b10)));
wire rx_keep = ~(ctl_ff[`ASIP_S_ADDR] & nine & ~rx_d[8]); // [RULE_20]
wire rx_try = (rxst_ff == RX_STOP) & rx_samp & rx_keep;
wire [2:0] rxn = rxw_ff - rxr_ff;
wire rx_full = (rxn == `ASIP_DEPTH);
wire rx_ovf = rx_try & rx_full; // [RULE_22]
wire overrun_fault_clr = wr_sta & wstrb_ff[0] & ~wdata_ff[`ASIP_S_OVERRUN_FAULT] & overrun_fault_ff;
wire rx_flush = overrun_fault_clr & ~rx_ovf; // [RULE_22]
wire rx_push = rx_try & ~rx_full & ~rx_flush;
wire rx_pop = rd_go & (s_axi_araddr_i == `ASIP_OFF_RXD) & (rxn != 3'd0); // [RULE_24]
wire [10:0] rx_head = rxq[rxr_ff[1:0]];
wire rx_quiet = (rxst_ff == RX_IDLE);

// rate measure: five falling edges of 55h span eight bits
wire abd_on = mode_ff[`ASIP_M_AUTO] & run;
wire rx_fall = rx_prev_ff & ~rx_bit;
wire abd_done = abd_on & rx_fall & (abd_fall_ff == `ASIP_ABD_FALLS); // [RULE_10]
wire [23:0] abd_per = fast ? (abd_cnt_ff >> 5) : (abd_cnt_ff >> 7);
wire [15:0] abd_brg = abd_per[15:0] - 16'd1;

// wake on start while asleep
wire wk_on = mode_ff[`ASIP_M_WAKE] & sys_sleep_i;
wire wk_fall = wk_on & lvl_prev_ff & ~rx_lvl;
wire wake_clr = wk_on & wk_seen_ff & rx_lvl & ~lvl_prev_ff; // [RULE_08]

// status word
wire [15:0] sta_rd = {ctl_ff[15:13], 1'b0, ctl_ff[11:10], tx_full, tx_empty,
                      ctl_ff[7:5], rx_quiet, rx_head[9] & (rxn != 3'd0),
                      rx_head[10] & (rxn != 3'd0), overrun_fault_ff, rxn != 3'd0}; // [RULE_21]

// read data mux
always @* begin
    case (s_axi_araddr_i)
        `ASIP_OFF_MODE: rd_val = mode_ff;
        `ASIP_OFF_STA: rd_val = sta_rd;
        `ASIP_OFF_RXD: rd_val = {7'h00, rx_head[8:0]};
        `ASIP_OFF_BRG: rd_val = brg_ff;
        default: rd_val = 16'h0000;
    endcase
end

// write channel: address and data in either order
always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        s_axi_awready_o <= 1'b0;
        s_axi_wready_o <= 1'b0;
        s_axi_bvalid_o <= 1'b0;
        s_axi_bresp_o <= `ASIP_RESP_OK;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        aw_a_ff <= 5'h00;
        wdata_ff <= 32'h00000000;
        wstrb_ff <= 4'h0;
    end else begin
        if (s_axi_awvalid_i & s_axi_awready_o) begin
            aw_have_ff <= 1'b1;
            aw_a_ff <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
        end else if (~aw_have_ff & ~s_axi_bvalid_o) begin
            s_axi_awready_o <= 1'b1;
        end
        if (s_axi_wvalid_i & s_axi_wready_o) begin
            w_have_ff <= 1'b1;
            wdata_ff <= s_axi_wdata_i;
            wstrb_ff <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
        end else if (~w_have_ff & ~s_axi_bvalid_o) begin
            s_axi_wready_o <= 1'b1;
        end
        if (wr_go) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? `ASIP_RESP_OK : `ASIP_RESP_ERR;
        end else if (s_axi_bvalid_o & s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end
end

// read channel
always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b0;
        s_axi_rdata_o <= 32'h00000000;
        s_axi_rresp_o <= `ASIP_RESP_OK;
    end else if (rd_go) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {16'h0000, rd_val};
        s_axi_rresp_o <= (s_axi_araddr_i[1:0] == 2'b00 &&
                          s_axi_araddr_i <= `ASIP_OFF_BRG) ? `ASIP_RESP_OK : `ASIP_RESP_ERR;
    end else if (s_axi_rvalid_o & s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
    end else if (~s_axi_rvalid_o) begin
        s_axi_arready_o <= 1'b1;
    end
end

// control registers; a software write beats a hardware clear
always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        mode_ff <= `ASIP_MODE_RST;
        ctl_ff <= `ASIP_STA_RST;
        brg_ff <= `ASIP_BRG_RST;
        overrun_fault_ff <= 1'b0;
    end else begin
        if (brk_done)
            ctl_ff[`ASIP_S_BRK] <= 1'b0; // [RULE_15]
        if (wake_clr)
            mode_ff[`ASIP_M_WAKE] <= 1'b0; // [RULE_08]
        if (abd_done) begin
            mode_ff[`ASIP_M_AUTO] <= 1'b0; // [RULE_10]
            brg_ff <= abd_brg;
        end
        if (wr_mode)
            mode_ff <= mrg(mode_ff) & `ASIP_MODE_WMASK;
        if (wr_sta)
            ctl_ff <= mrg(ctl_ff) & `ASIP_STA_WMASK;
        if (wr_brg)
            brg_ff <= mrg(brg_ff);
        // an overflow in the clearing cycle keeps the flag set
        if (rx_ovf)
            overrun_fault_ff <= 1'b1; // [RULE_22]
        else if (overrun_fault_clr)
            overrun_fault_ff <= 1'b0;
    end
end

// pin synchronisers: level taken once stages two and three agree
always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        rxs_ff <= 3'b111;
        ctss_ff <= 3'b111;
        rx_pin_ff <= 1'b1;
        cts_ff <= 1'b1;
    end else begin
        rxs_ff <= {rxs_ff[1:0], serial_in_pin_i};
        ctss_ff <= {ctss_ff[1:0], clear_to_send_pin_i};
        if (rxs_ff[1] == rxs_ff[2])
            rx_pin_ff <= rxs_ff[2];
        if (ctss_ff[1] == ctss_ff[2])
            cts_ff <= ctss_ff[2];
    end
end

// rate timer; restarting on a divider write avoids waiting out the old period
always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i)
        bcnt_ff <= 16'h0000;
    else if (wr_brg | abd_done)
        bcnt_ff <= 16'h0000; // [RULE_23]
    else if (run)
        bcnt_ff <= os_tick ? 16'h0000 : bcnt_ff + 16'd1; // [RULE_23]
end

// queue storage unreset; pointers qualify each entry
always @(posedge clk_sys_i) begin
    if (tx_push)
        txq[txw_ff[1:0]] <= wdata_ff[8:0];
    if (rx_push)
        rxq[rxw_ff[1:0]] <= {~rx_bit, rx_parity_fault, rx_d}; // [RULE_21]
end

// transmitter: whole frame loaded, shifted out lsb first
always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        txw_ff <= 3'd0;
        txr_ff <= 3'd0;
        tx_sh_ff <= 15'h7fff;
        tx_left_ff <= 4'd0;
        tx_os_ff <= 4'd0;
        tx_busy_ff <= 1'b0;
        tx_brk_ff <= 1'b0;
    end else begin
        if (tx_push)
            txw_ff <= txw_ff + 3'd1;
        if (tx_flush) begin
            txr_ff <= txw_ff; // [RULE_16]
            tx_busy_ff <= 1'b0;
        end else if (tx_load) begin
            txr_ff <= txr_ff + 3'd1;
            tx_busy_ff <= 1'b1;
            tx_os_ff <= 4'd0;
            tx_brk_ff <= ctl_ff[`ASIP_S_BRK];
            if (ctl_ff[`ASIP_S_BRK]) begin
                tx_sh_ff <= {2'b11, 13'h0000}; // [RULE_15]
                tx_left_ff <= `ASIP_BRK_LEN;
            end else if (nine) begin
                tx_sh_ff <= {5'h1f, txd, 1'b0}; // [RULE_13]
                tx_left_ff <= `ASIP_LEN9 + {3'd0, stop2};
            end else if (pd != 2'b00) begin
                tx_sh_ff <= {5'h1f, par_bit, txd[7:0], 1'b0}; // [RULE_13]
                tx_left_ff <= `ASIP_LEN9 + {3'd0, stop2};
            end else begin
                tx_sh_ff <= {6'h3f, txd[7:0], 1'b0}; // [RULE_13]
                tx_left_ff <= `ASIP_LEN8 + {3'd0, stop2};
            end
        end else if (tx_busy_ff & os_tick) begin
            if (tx_os_ff == ovs_last) begin
                tx_os_ff <= 4'd0;
                tx_sh_ff <= {1'b1, tx_sh_ff[14:1]};
                tx_left_ff <= tx_left_ff - 4'd1;
                if (tx_left_ff == 4'd1)
                    tx_busy_ff <= 1'b0;
            end else begin
                tx_os_ff <= tx_os_ff + 4'd1;
            end
        end
    end
end

// receiver, sampling each bit mid-cell
always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        rxst_ff <= RX_IDLE;
        rx_os_ff <= 4'd0;
        rx_n_ff <= 4'd0;
        rx_sh_ff <= 10'h000;
    end else if (rx_flush | ~run | abd_on) begin
        rxst_ff <= RX_IDLE; // [RULE_22]
    end else begin
        case (rxst_ff)
            RX_IDLE: begin
                rx_os_ff <= 4'd0;
                if (~rx_bit)
                    rxst_ff <= RX_START;
            end
            RX_START: if (os_tick) begin
                if (rx_os_ff == {1'b0, ovs_last[3:1]}) begin
                    rxst_ff <= rx_bit ? RX_IDLE : RX_DATA;
                    rx_os_ff <= 4'd0;
                    rx_n_ff <= 4'd0;
                end else begin
                    rx_os_ff <= rx_os_ff + 4'd1;
                end
            end
            RX_DATA: if (os_tick) begin
                if (rx_samp) begin
                    rx_os_ff <= 4'd0;
                    rx_sh_ff <= {rx_bit, rx_sh_ff[9:1]}; // [RULE_13]
                    rx_n_ff <= rx_n_ff + 4'd1;
                    if (rx_n_ff == rx_nbits - 4'd1)
                        rxst_ff <= RX_STOP;
                end else begin
                    rx_os_ff <= rx_os_ff + 4'd1;
                end
            end
            RX_STOP: if (os_tick) begin
                if (rx_samp)
                    rxst_ff <= RX_IDLE;
                else
                    rx_os_ff <= rx_os_ff + 4'd1;
            end
            default: rxst_ff <= RX_IDLE;
        endcase
    end
end

// rx pointers, infrared stretch, rate measure, wake
always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        rxw_ff <= 3'd0;
        rxr_ff <= 3'd0;
        irh_ff <= 4'd0;
        rx_prev_ff <= 1'b1;
        lvl_prev_ff <= 1'b1;
        abd_cnt_ff <= 24'h000000;
        abd_fall_ff <= 3'd0;
        wk_seen_ff <= 1'b0;
    end else begin
        if (rx_push)
            rxw_ff <= rxw_ff + 3'd1;
        if (rx_flush)
            rxr_ff <= rxw_ff; // [RULE_22]
        else if (rx_pop)
            rxr_ff <= rxr_ff + 3'd1; // [RULE_24]
        // a pulse holds the decoded line low about one bit
        if (~rx_lvl)
            irh_ff <= `ASIP_IR_HOLD; // [RULE_03]
        else if (os_tick & (irh_ff != 4'd0))
            irh_ff <= irh_ff - 4'd1;
        rx_prev_ff <= rx_bit;
        lvl_prev_ff <= rx_lvl;
        if (~abd_on) begin
            abd_cnt_ff <= 24'h000000;
            abd_fall_ff <= 3'd0;
        end else begin
            if (abd_fall_ff != 3'd0)
                abd_cnt_ff <= abd_cnt_ff + 24'd1; // [RULE_10]
            if (rx_fall)
                abd_fall_ff <= abd_fall_ff + 3'd1;
        end
        if (~wk_on | wake_clr)
            wk_seen_ff <= 1'b0;
        else if (wk_fall)
            wk_seen_ff <= 1'b1;
    end
end

// pins and event pulses
always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        serial_out_pin_o <= 1'b1;
        serial_out_pin_oe_o <= 1'b0;
        request_to_send_pin_o <= 1'b1;
        request_to_send_pin_oe_o <= 1'b0;
        tx_irq_o <= 1'b0;
        rx_irq_o <= 1'b0;
        wake_irq_o <= 1'b0;
    end else begin
        serial_out_pin_o <= ir_on ? (ir_pulse ^ ctl_ff[`ASIP_S_TXPOL]) : tx_line; // [RULE_03]
        serial_out_pin_oe_o <= pin_en & txen; // [RULE_04] [RULE_16]
        request_to_send_pin_oe_o <= pin_en & (pins != 2'b00); // [RULE_04] [RULE_07]
        // rate clock high for first half of each divider period
        case (pins)
            2'b11: request_to_send_pin_o <= run & ~fast &
                                            (bcnt_ff <= {1'b0, brg_ff[15:1]}); // [RULE_02]
            2'b10, 2'b01: request_to_send_pin_o <= mode_ff[`ASIP_M_RQSX] ?
                                                   ~tx_busy_ff : rx_full; // [RULE_06]
            default: request_to_send_pin_o <= 1'b1;
        endcase
        case ({ctl_ff[`ASIP_S_TXIS1], ctl_ff[`ASIP_S_TXIS0]})
            2'b00: tx_irq_o <= tx_load; // [RULE_14]
            2'b10: tx_irq_o <= tx_load & (txn == 3'd1); // [RULE_14]
            2'b01: tx_irq_o <= tx_fin & (txn == 3'd0); // [RULE_14]
            default: tx_irq_o <= 1'b0;
        endcase
        case (ctl_ff[`ASIP_S_RXIS])
            2'b11: rx_irq_o <= rx_push & (rxn == 3'd3); // [RULE_19]
            2'b10: rx_irq_o <= rx_push & (rxn == 3'd2); // [RULE_19]
            default: rx_irq_o <= rx_push; // [RULE_19]
        endcase
        wake_irq_o <= wk_fall & ~wk_seen_ff; // [RULE_08]
    end
end
endmodule // asip_uart

// ### tb_top.sv
`timescale 1ns/100ps
`include "asip_defines.vh"
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rv, rr;
    logic [15:0] d;
    logic [7:0] q [0:4];
    logic prev;
    wire awready, wready, bvalid, arready, rvalid, txo, txoe, rts, rtsoe, txi, rxi, rx_line, cts_n;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int errors = 0, n_tests = 0, n_rxi = 0, seed = 32'hfacd, i, j, n;
    // transmit line pulled up while undriven
    wire tx_line = txoe ? txo : 1'b1;
    always #4 clk = ~clk;
    asip_uart i_dut (.clk_sys_i(clk), .sys_rst_i(rst), .sys_idle_i(1'b0), .sys_sleep_i(1'b0),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .serial_in_pin_i(rx_line),
        .clear_to_send_pin_i(cts_n), .serial_out_pin_o(txo), .serial_out_pin_oe_o(txoe),
        .request_to_send_pin_o(rts), .request_to_send_pin_oe_o(rtsoe), .tx_irq_o(txi),
        .rx_irq_o(rxi), .wake_irq_o());
    asip_partner #(.BIT(16)) i_prt (.clk_i(clk), .line_i(tx_line), .line_o(rx_line),
        .cts_n_o(cts_n));
    always @(posedge clk) if (rxi === 1'b1) n_rxi++;
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // write: aw and w offered together, each dropped when taken
    task wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, v};
        {awvalid, wvalid, bready} <= 3'b111;
        while (bvalid !== 1'b1) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task rd(input logic [4:0] a);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        while (rvalid !== 1'b1) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        rv = rdata;
        rr = {30'h0, rresp};
        rready <= 1'b0;
    endtask
    // poll status until bit b reads v
    task poll(input int b, input logic v);
        rd(`ASIP_OFF_STA);
        while (rv[b] !== v) rd(`ASIP_OFF_STA);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog far above the serial traffic
    initial begin
        #(8 * 90000);
        errors++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`ASIP_OFF_STA);
        chk("sta reset", rv, 32'h00000110);
        rd(5'h14);
        chk("unmapped", rr, 32'h2);
        // fields written with the port off
        for (i = 0; i < 4; i++) begin
            d = $random(seed) & 16'h7fff;
            wr(`ASIP_OFF_MODE, d);
            rd(`ASIP_OFF_MODE);
            chk("mode rw", rv, {16'h0000, d & `ASIP_MODE_WMASK});
        end
        // divider 1: two-clock rate clock; fast rate stops it
        wr(`ASIP_OFF_BRG, 16'h0001);
        for (j = 0; j < 2; j++) begin
            wr(`ASIP_OFF_MODE, 16'h8300 | (j << 3));
            repeat (8) @(posedge clk);
            n = 0;
            prev = rts;
            repeat (32) begin
                @(posedge clk);
                if (rts === 1'b1 && prev === 1'b0) n++;
                prev = rts;
            end
            chk("rate clock", n, j ? 0 : 16);
            chk("rts oe", rtsoe, 1'b1);
        end
        wr(`ASIP_OFF_BRG, 16'h0000);
        wr(`ASIP_OFF_MODE, 16'h8000);
        wr(`ASIP_OFF_STA, 16'h04c0);
        q[0] = $random(seed);
        wr(`ASIP_OFF_TXD, q[0]);
        poll(8, 1'b1);
        chk("tx byte", i_prt.got, q[0]);
        for (i = 0; i < 4; i++) begin
            q[i] = $random(seed);
            i_prt.send({3'b000, q[i]}, 8);
        end
        chk("rx events", n_rxi, 1);
        for (i = 0; i < 4; i++) begin
            rd(`ASIP_OFF_RXD);
            chk("rx order", rv, q[i]);
        end
        for (i = 0; i < 5; i++) i_prt.send({3'b000, q[0]}, 8);
        rd(`ASIP_OFF_STA);
        chk("overrun", rv[1], 1'b1);
        wr(`ASIP_OFF_STA, 16'h04c0);
        rd(`ASIP_OFF_STA);
        chk("flushed", rv[0], 1'b0);
        // odd parity: first wrong, second right
        wr(`ASIP_OFF_MODE, 16'h8004);
        i_prt.send({2'b00, ^q[1], q[1]}, 9);
        i_prt.send({2'b00, ~^q[2], q[2]}, 9);
        rd(`ASIP_OFF_STA);
        chk("parity head", rv[3], 1'b1);
        rd(`ASIP_OFF_RXD);
        rd(`ASIP_OFF_STA);
        chk("parity next", rv[3], 1'b0);
        rd(`ASIP_OFF_RXD);
        // break eats the dummy character, then clears itself
        wr(`ASIP_OFF_MODE, 16'h8000);
        wr(`ASIP_OFF_STA, 16'h0cc0);
        wr(`ASIP_OFF_TXD, 16'h00ff);
        poll(11, 1'b0);
        poll(8, 1'b1);
        chk("break bit", rv[11], 1'b0);
        chk("break zeros", i_prt.got, 8'h00);
        wr(`ASIP_OFF_MODE, 16'h8040);
        q[3] = $random(seed);
        wr(`ASIP_OFF_TXD, q[3]);
        poll(0, 1'b1);
        rd(`ASIP_OFF_RXD);
        chk("echo", rv, q[3]);
        end_sim;
    end
endmodule // tb_top
bind asip_uart asip_assertions i_chk (.clk_sys_i, .sys_rst_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .tx_irq_o, .rx_irq_o);
